// file: verilog/dmfc_pkg.sv
// constants and types for the dds mode and frequency control block
// Contract
// - mode comes from control byte 1f
// - codes: tone, fsk, ramp, chirp, bpsk
// - master reset forces single tone mode
// - single tone feeds tuning word one
// - reset gives zero frequency, zero phase
// - tuning word is 48-bit phase increment
// - frequency changes keep accumulator phase
// - quadrature outputs 90 degrees apart once out of reset (both zero in reset)
// - functions gated per mode
// - fsk: pin low word one, high two
// - keying pin to output fixed latency
// - ramp uses 48-bit step, 20-bit rate
// - rate loads 20-bit down-counter, pulses zero
// - counter starts on pin change, per clock
// - step and rate rewrites apply mid-ramp
// - pulse interval is rate plus one
// - pulse adds step to frequency accumulator with pin high, subtracts it in ramp with pin low
// - counter stops at destination frequency
package dmfc_pkg;
    localparam int FW = 48;
    localparam int RW = 20;
    localparam int PW = 14;
    localparam int BYTE_W = 8;
    localparam int ADDR_W = 6;
    localparam int REG_BYTES = 32;
    localparam int REG_IDX_W = 5;
    localparam int TW_BYTES = 6;
    localparam int RATE_BYTES = 3;
    localparam int PHASE_BYTES = 2;
    // byte addresses, lowest address holds the most significant byte
    localparam int ADDR_PHASE1 = 'h00;
    localparam int ADDR_PHASE2 = 'h02;
    localparam int ADDR_TW1 = 'h04;
    localparam int ADDR_TW2 = 'h0a;
    localparam int ADDR_STEP = 'h10;
    localparam int ADDR_RATE = 'h1a;
    localparam int ADDR_MODE_CTRL = 'h1f;
    localparam int ADDR_STATUS = 'h20;
    // control byte fields
    localparam int CTRL_MODE_LSB = 1;
    localparam int CTRL_MODE_W = 3;
    localparam int CTRL_FREQ_ACC_CLEAR_BIT = 7;
    // status byte fields
    localparam int STAT_MODE_LSB = 0;
    localparam int STAT_PIN_BIT = 3;
    localparam int STAT_AT_DEST_BIT = 4;
    localparam int STAT_RUNNING_BIT = 5;
    localparam logic [CTRL_MODE_W-1:0] MODE_CODE_TONE = 3'h0;
    localparam logic [CTRL_MODE_W-1:0] MODE_CODE_FSK = 3'h1;
    localparam logic [CTRL_MODE_W-1:0] MODE_CODE_RAMP = 3'h2;
    localparam logic [CTRL_MODE_W-1:0] MODE_CODE_CHIRP = 3'h3;
    localparam logic [CTRL_MODE_W-1:0] MODE_CODE_BPSK = 3'h4;
    localparam logic [PW-1:0] QUARTER_TURN = 14'h1000;

    typedef enum logic [4:0] {
        MODE_TONE = 5'h01,
        MODE_FSK = 5'h02,
        MODE_RAMP = 5'h04,
        MODE_CHIRP = 5'h08,
        MODE_BPSK = 5'h10
    } dmfc_mode_t;

    // bit position of a field inside the flattened register image
    function automatic int dmfc_flat_pos(input int base_addr, input int nbytes);
        return (REG_BYTES - base_addr - nbytes) * BYTE_W;
    endfunction
endpackage

// file: verilog/dmfc_rate_if.sv
// signals between the mode control and the ramp rate counter
`timescale 1ns/100ps
interface dmfc_rate_if;
    import dmfc_pkg::*;
    logic [RW-1:0] reload_val;
    logic start;
    logic stop;
    logic pulse;
    logic running;
    logic [RW-1:0] count;
    modport ctrl (output reload_val, start, stop, input pulse, running, count);
    modport counter (input reload_val, start, stop, output pulse, running, count);
endinterface

// file: verilog/dmfc_rate_counter.sv
// ramp rate down-counter emitting one pulse per expiry
`timescale 1ns/100ps
module dmfc_rate_counter
    import dmfc_pkg::*;
(
    // clock and reset
    input wire logic i_clk_sys,
    input wire logic i_rst,
    // link to mode control
    dmfc_rate_if.counter port
);
    logic [RW-1:0] cnt_reg;
    logic [RW-1:0] cnt_next;
    logic run_reg;
    logic run_next;
    logic pulse_reg;
    logic pulse_next;
    wire at_zero = (cnt_reg == '0);
    // start wins over stop so a pin change in ramp always restarts
    wire active = run_reg & ~port.stop & ~port.start;

    // reload takes the live register value, so rewrites act mid-ramp
    assign cnt_next = (port.start | (active & at_zero)) ? port.reload_val :
                      active ? cnt_reg - RW'(1) : cnt_reg;
    assign run_next = port.start | (run_reg & ~port.stop);
    assign pulse_next = active & at_zero;

    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            cnt_reg <= '0;
            run_reg <= 1'b0;
            pulse_reg <= 1'b0;
        end else begin
            cnt_reg <= cnt_next;
            run_reg <= run_next;
            pulse_reg <= pulse_next;
        end
    end

    assign port.count = cnt_reg;
    assign port.running = run_reg;
    assign port.pulse = pulse_reg;

    // helper: cycles between pulses and the value loaded for that interval
    logic [RW:0] gap_reg;
    logic [RW-1:0] cur_load_reg;
    logic [RW-1:0] prev_load_reg;
    logic clean_reg;
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            gap_reg <= '0;
            cur_load_reg <= '0;
            prev_load_reg <= '0;
            clean_reg <= 1'b0;
        end else begin
            gap_reg <= pulse_reg ? (RW+1)'(1) : gap_reg + (RW+1)'(1);
            cur_load_reg <= (port.start | (active & at_zero)) ? port.reload_val : cur_load_reg;
            prev_load_reg <= pulse_reg ? cur_load_reg : prev_load_reg;
            clean_reg <= pulse_reg ? 1'b1 : clean_reg & ~port.start & ~port.stop;
        end
    end

    rate_interval_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        pulse_reg && clean_reg |-> gap_reg == {1'b0, prev_load_reg} + (RW+1)'(1))
        else $error("rate pulse interval is not the loaded value plus one");

    start_load_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        port.start |=> run_reg && cnt_reg == $past(port.reload_val) && !pulse_reg)
        else $error("counter did not load and run on start");
endmodule

// file: verilog/dmfc_top.sv
// dds mode selection, tuning word steering and ramped frequency control
`timescale 1ns/100ps
module dmfc_top
    import dmfc_pkg::*;
(
    // clock and master reset
    input wire logic i_clk_sys,
    input wire logic i_rst,
    // parallel programming port
    input wire logic [ADDR_W-1:0] i_addr,
    input wire logic i_wr_en,
    input wire logic [BYTE_W-1:0] i_wdata,
    input wire logic i_rd_en,
    output logic [BYTE_W-1:0] o_rdata,
    // keying pin
    input wire logic i_keying_select_pin,
    // synthesis path
    output logic [FW-1:0] o_freq_word,
    output logic [PW-1:0] o_phase_cos,
    output logic [PW-1:0] o_phase_sin,
    output logic o_rate_pulse
);
    // register image
    logic [BYTE_W-1:0] reg_mem [REG_BYTES];
    logic [REG_BYTES*BYTE_W-1:0] reg_flat;

    for (genvar g = 0; g < REG_BYTES; g++) begin : g_flat
        assign reg_flat[(REG_BYTES-1-g)*BYTE_W +: BYTE_W] = reg_mem[g];
    end

    wire [FW-1:0] tuning_word_one = reg_flat[dmfc_flat_pos(ADDR_TW1, TW_BYTES) +: FW];
    wire [FW-1:0] tuning_word_two = reg_flat[dmfc_flat_pos(ADDR_TW2, TW_BYTES) +: FW];
    wire [FW-1:0] ramp_step_word = reg_flat[dmfc_flat_pos(ADDR_STEP, TW_BYTES) +: FW];
    wire [RATE_BYTES*BYTE_W-1:0] rate_bytes =
        reg_flat[dmfc_flat_pos(ADDR_RATE, RATE_BYTES) +: RATE_BYTES*BYTE_W];
    wire [RW-1:0] ramp_rate_count = rate_bytes[RW-1:0];
    wire [PHASE_BYTES*BYTE_W-1:0] phase1_bytes =
        reg_flat[dmfc_flat_pos(ADDR_PHASE1, PHASE_BYTES) +: PHASE_BYTES*BYTE_W];
    wire [PHASE_BYTES*BYTE_W-1:0] phase2_bytes =
        reg_flat[dmfc_flat_pos(ADDR_PHASE2, PHASE_BYTES) +: PHASE_BYTES*BYTE_W];
    wire [BYTE_W-1:0] mode_control = reg_mem[ADDR_MODE_CTRL];

    // mode decode
    wire [CTRL_MODE_W-1:0] mode_code = mode_control[CTRL_MODE_LSB +: CTRL_MODE_W];
    dmfc_mode_t mode;
    // unlisted codes fall back to single tone so the output stays defined
    assign mode = (mode_code == MODE_CODE_FSK) ? MODE_FSK :
                  (mode_code == MODE_CODE_RAMP) ? MODE_RAMP :
                  (mode_code == MODE_CODE_CHIRP) ? MODE_CHIRP :
                  (mode_code == MODE_CODE_BPSK) ? MODE_BPSK :
                  MODE_TONE;
    wire is_ramp = (mode == MODE_RAMP);
    wire is_chirp = (mode == MODE_CHIRP);

    // programming port decode
    wire [REG_IDX_W-1:0] reg_idx = i_addr[REG_IDX_W-1:0];
    wire addr_in_image = (i_addr < ADDR_W'(REG_BYTES));
    wire addr_is_status = (i_addr == ADDR_W'(ADDR_STATUS));
    wire wr_image = i_wr_en & addr_in_image;

    // keying pin edges
    logic pin_prev_reg;
    logic clr_prev_reg;
    dmfc_mode_t mode_prev_reg;
    wire pin = i_keying_select_pin;
    wire pin_change = pin ^ pin_prev_reg;
    wire pin_fall = pin_prev_reg & ~pin;
    wire clr_bit = mode_control[CTRL_FREQ_ACC_CLEAR_BIT];
    // one clear per rising edge; holding the bit high does not keep clearing
    wire clr_pulse = clr_bit & ~clr_prev_reg;
    wire chirp_enter = is_chirp & (mode_prev_reg != MODE_CHIRP);

    // frequency accumulator
    logic [FW-1:0] facc_reg;
    logic [FW-1:0] facc_next;
    wire [FW-1:0] span = tuning_word_two - tuning_word_one;
    wire [FW:0] sum_up = {1'b0, facc_reg} + {1'b0, ramp_step_word};
    wire [FW-1:0] sat_up = (sum_up[FW] | (sum_up[FW-1:0] >= span)) ? span : sum_up[FW-1:0];
    wire [FW-1:0] sat_dn = (facc_reg > ramp_step_word) ? facc_reg - ramp_step_word : '0;
    // pin high heads for the high word, low heads back to the low word
    wire at_dest = pin ? (facc_reg == span) : (facc_reg == '0);
    wire ramp_step = is_ramp & rate.pulse;
    wire chirp_step = is_chirp & rate.pulse;
    wire sweep_mode = is_ramp | is_chirp;

    assign facc_next = (clr_pulse | ~sweep_mode) ? '0 :
                       ramp_step ? (pin ? sat_up : sat_dn) :
                       chirp_step ? sum_up[FW-1:0] :
                       facc_reg;

    // rate counter control
    dmfc_rate_if rate();
    assign rate.reload_val = ramp_rate_count;
    assign rate.start = (is_ramp & pin_change) | (is_chirp & (chirp_enter | pin_fall));
    // chirp holds its sweep while the pin is high
    assign rate.stop = ~sweep_mode | (is_ramp & at_dest) | (is_chirp & pin);

    dmfc_rate_counter u_rate (
        .i_clk_sys(i_clk_sys),
        .i_rst(i_rst),
        .port(rate.counter)
    );

    // tuning word steering, registered so the pin sees a fixed latency
    logic [FW-1:0] freq_next;
    always_comb begin
        case (mode)
            MODE_TONE: freq_next = tuning_word_one;
            MODE_FSK: freq_next = pin ? tuning_word_two : tuning_word_one;
            MODE_RAMP: freq_next = tuning_word_one + facc_reg;
            MODE_CHIRP: freq_next = tuning_word_one + facc_reg;
            MODE_BPSK: freq_next = tuning_word_one;
            default: freq_next = tuning_word_one;
        endcase
    end

    // phase offset: bpsk keys between the two adjusts, others use the first
    wire [PW-1:0] phase_one = phase1_bytes[PW-1:0];
    wire [PW-1:0] phase_two = phase2_bytes[PW-1:0];
    wire [PW-1:0] phase_offset = (mode == MODE_BPSK && pin) ? phase_two : phase_one;

    // phase accumulator never reloads, so tuning changes stay continuous
    logic [FW-1:0] phase_acc_reg;
    wire [FW-1:0] phase_acc_next = phase_acc_reg + o_freq_word;
    wire [PW-1:0] phase_base = phase_acc_reg[FW-1 -: PW] + phase_offset;
    wire [PW-1:0] phase_quad = phase_base + QUARTER_TURN;

    // status readback
    logic [BYTE_W-1:0] status_byte;
    always_comb begin
        status_byte = '0;
        status_byte[STAT_MODE_LSB +: CTRL_MODE_W] = mode_code;
        status_byte[STAT_PIN_BIT] = pin;
        status_byte[STAT_AT_DEST_BIT] = is_ramp & at_dest;
        status_byte[STAT_RUNNING_BIT] = rate.running;
    end
    wire [BYTE_W-1:0] rd_sel = addr_in_image ? reg_mem[reg_idx] :
                               addr_is_status ? status_byte : '0;

    // register image writes; reset leaves every byte zero
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            for (int k = 0; k < REG_BYTES; k++) begin
                reg_mem[k] <= '0;
            end
        end else if (wr_image) begin
            reg_mem[reg_idx] <= i_wdata;
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            pin_prev_reg <= 1'b0;
            clr_prev_reg <= 1'b0;
            mode_prev_reg <= MODE_TONE;
            facc_reg <= '0;
        end else begin
            pin_prev_reg <= pin;
            clr_prev_reg <= clr_bit;
            mode_prev_reg <= mode;
            facc_reg <= facc_next;
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            phase_acc_reg <= '0;
            o_freq_word <= '0;
            o_phase_cos <= '0;
            o_phase_sin <= '0;
            o_rate_pulse <= 1'b0;
            o_rdata <= '0;
        end else begin
            phase_acc_reg <= phase_acc_next;
            o_freq_word <= freq_next;
            o_phase_cos <= phase_base;
            o_phase_sin <= phase_quad;
            o_rate_pulse <= rate.pulse;
            o_rdata <= i_rd_en ? rd_sel : o_rdata;
        end
    end

    mode_reset_a: assert property (@(posedge i_clk_sys)
        i_rst |=> mode == MODE_TONE && o_freq_word == '0)
        else $error("reset did not select single tone at zero frequency");

    reserved_code_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        mode_code > MODE_CODE_BPSK |-> mode == MODE_TONE)
        else $error("reserved mode code did not act as single tone");

    tone_pin_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        mode == MODE_TONE |=> o_freq_word == $past(tuning_word_one))
        else $error("single tone did not use tuning word one");

    fsk_low_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        mode == MODE_FSK && !pin |=> o_freq_word == $past(tuning_word_one))
        else $error("fsk low did not select tuning word one");

    fsk_high_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        mode == MODE_FSK && pin |=> o_freq_word == $past(tuning_word_two))
        else $error("fsk high did not select tuning word two");

    // outputs leave reset both zero, so skip the first edge after release
    quad_offset_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        !$past(i_rst) |-> (o_phase_sin - o_phase_cos) == QUARTER_TURN)
        else $error("quadrature outputs not a quarter turn apart");

    ramp_bound_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        is_ramp && $past(is_ramp) && $stable(span) && $past(facc_reg <= span) && !$past(clr_pulse)
        |-> facc_reg <= span)
        else $error("ramp accumulator passed the destination");

    ramp_stop_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        is_ramp && at_dest && !pin_change |=> !rate.running ##1 !rate.pulse)
        else $error("rate counter kept running at destination");
endmodule

// file: testbench/dmfc_host_model.sv
// host controller model: programs registers and drives the keying pin
`timescale 1ns/100ps
module dmfc_host_model
    import dmfc_pkg::*;
(
    // clock
    input wire logic i_clk_sys,
    // programming port
    output logic [ADDR_W-1:0] o_addr,
    output logic o_wr_en,
    output logic [BYTE_W-1:0] o_wdata,
    output logic o_rd_en,
    input wire logic [BYTE_W-1:0] i_rdata,
    // keying pin
    output logic o_keying_select_pin
);
    initial begin
        o_addr = '0;
        o_wr_en = 1'b0;
        o_wdata = '0;
        o_rd_en = 1'b0;
        o_keying_select_pin = 1'b0;
    end

    // released lines show the inverse so a stale value never passes
    task automatic bus_cycle(input logic [ADDR_W-1:0] a, input logic [BYTE_W-1:0] d,
                             input logic wr);
        @(posedge i_clk_sys);
        o_addr <= a;
        o_wdata <= d;
        o_wr_en <= wr;
        o_rd_en <= !wr;
        @(posedge i_clk_sys);
        o_wr_en <= 1'b0;
        o_rd_en <= 1'b0;
        o_addr <= ~a;
        o_wdata <= ~d;
    endtask

    task automatic write_byte(input logic [ADDR_W-1:0] a, input logic [BYTE_W-1:0] d);
        bus_cycle(a, d, 1'b1);
    endtask

    task automatic read_byte(input logic [ADDR_W-1:0] a, output logic [BYTE_W-1:0] d);
        bus_cycle(a, 8'h00, 1'b0);
        #1;
        d = i_rdata;
    endtask

    // big-endian: lowest address gets the top byte
    task automatic write_word(input logic [ADDR_W-1:0] a, input logic [FW-1:0] v);
        for (int i = 0; i < TW_BYTES; i++) begin
            write_byte(a + ADDR_W'(i), v[(TW_BYTES-1-i)*BYTE_W +: BYTE_W]);
        end
    endtask

    // clear pulse low-high-low so the ramp starts from zero
    task automatic clear_acc(input logic [CTRL_MODE_W-1:0] m);
        write_byte(ADDR_MODE_CTRL, {4'h0, m, 1'b0});
        write_byte(ADDR_MODE_CTRL, {4'h8, m, 1'b0});
        write_byte(ADDR_MODE_CTRL, {4'h0, m, 1'b0});
    endtask

    task automatic set_pin(input logic v);
        @(posedge i_clk_sys);
        o_keying_select_pin <= v;
    endtask
endmodule

// file: testbench/tb.sv
// self-checking bench for the mode and frequency control block
`timescale 1ns/100ps
module tb
    import dmfc_pkg::*;
;
    typedef struct packed {
        logic [ADDR_W-1:0] a;
        logic [BYTE_W-1:0] d;
        logic [BYTE_W-1:0] e;
    } dmfc_row_t;
    localparam logic [FW-1:0] T1 = 48'h0000_1000_0000;
    localparam logic [FW-1:0] S = 48'h0000_0100_0000;
    localparam logic [FW-1:0] T2 = T1 + 3 * S;
    localparam int N = 3;
    // write value beside the value a read-back must return
    localparam dmfc_row_t ROWS [8] = '{
        '{6'h04, 8'h12, 8'h12}, '{6'h09, 8'hff, 8'hff}, '{6'h0a, 8'h5a, 8'h5a},
        '{6'h0f, 8'ha5, 8'ha5}, '{6'h10, 8'h01, 8'h01}, '{6'h1c, 8'h33, 8'h33},
        '{6'h25, 8'haa, 8'h00}, '{6'h3f, 8'h11, 8'h00}};
    logic clk, rst, wr_en, rd_en, pin, pulse;
    logic [ADDR_W-1:0] addr;
    logic [BYTE_W-1:0] wdata, rdata, rd;
    logic [FW-1:0] freq;
    logic [PW-1:0] cos_w, sin_w;
    int err_total = 0;
    int comparisons = 0;
    int n;

    dmfc_top uut (.i_clk_sys(clk), .i_rst(rst), .i_addr(addr), .i_wr_en(wr_en),
        .i_wdata(wdata), .i_rd_en(rd_en), .o_rdata(rdata), .i_keying_select_pin(pin),
        .o_freq_word(freq), .o_phase_cos(cos_w), .o_phase_sin(sin_w), .o_rate_pulse(pulse));
    dmfc_host_model host (.i_clk_sys(clk), .o_addr(addr), .o_wr_en(wr_en), .o_wdata(wdata),
        .o_rd_en(rd_en), .i_rdata(rdata), .o_keying_select_pin(pin));

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    task automatic check(input logic [FW-1:0] seen, input logic [FW-1:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_total++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic end_sim();
        $display("comparisons %0d, mismatches %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic settle(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask

    // edges until the rate pulse shows, capped at 60
    task automatic wait_pulse(output int cnt);
        cnt = 0;
        do begin
            @(posedge clk);
            #1;
            cnt++;
        end while (pulse !== 1'b1 && cnt < 60);
    endtask

    // quadrature offset must survive any phase offset setting
    task automatic phase_step(input logic [PW-1:0] exp);
        logic [PW-1:0] p;
        logic [PW-1:0] dp;
        logic [PW-1:0] q;
        p = cos_w;
        settle(1);
        dp = cos_w - p;
        q = sin_w - cos_w;
        check(FW'(dp), FW'(exp));
        check(FW'(q), FW'(QUARTER_TURN));
    endtask

    initial begin
        #(3000 * 100);
        err_total++;
        end_sim();
    end

    initial begin
        rst = 1'b1;
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        settle(1);
        check(freq, '0);
        check(FW'(cos_w), '0);
        host.read_byte(ADDR_MODE_CTRL, rd);
        check(FW'(rd), '0);
        host.read_byte(ADDR_TW1 + 5, rd);
        check(FW'(rd), '0);
        foreach (ROWS[i]) begin
            host.write_byte(ROWS[i].a, ROWS[i].d);
            host.read_byte(ROWS[i].a, rd);
            check(FW'(rd), FW'(ROWS[i].e));
        end
        host.write_word(ADDR_TW1, 48'h1000_0000_0000);
        host.write_word(ADDR_TW2, 48'h2000_0000_0000);
        host.write_word(ADDR_STEP, '0);
        host.write_byte(ADDR_MODE_CTRL, 8'h00);
        host.write_byte(ADDR_PHASE1 + 1, 8'h23);
        host.set_pin(1'b1);
        settle(3);
        check(freq, 48'h1000_0000_0000);
        phase_step(14'h400);
        // every code but ramp, pin high: only fsk takes word two
        for (int m = 0; m < 8; m++) begin
            if (m == 2) continue;
            host.write_byte(ADDR_MODE_CTRL, 8'(m << 1));
            settle(2);
            check(freq, (m == 1) ? 48'h2000_0000_0000 : 48'h1000_0000_0000);
            host.read_byte(ADDR_STATUS, rd);
            check(FW'(rd[2:0]), FW'(m));
        end
        host.write_byte(ADDR_MODE_CTRL, 8'h02);
        host.set_pin(1'b0);
        settle(2);
        check(freq, 48'h1000_0000_0000);
        host.set_pin(1'b1);
        settle(1);
        check(freq, 48'h2000_0000_0000);
        settle(2);
        phase_step(14'h800);
        // ramp: low end in word one, positive step
        host.set_pin(1'b0);
        host.write_word(ADDR_TW1, T1);
        host.write_word(ADDR_TW2, T2);
        host.write_word(ADDR_STEP, S);
        host.write_byte(ADDR_RATE + 2, 8'(N));
        host.clear_acc(MODE_CODE_RAMP);
        settle(2);
        check(freq, T1);
        host.set_pin(1'b1);
        wait_pulse(n);
        check(FW'(n), FW'(N + 3));
        for (int k = 1; k <= 3; k++) begin
            settle(1);
            check(freq, T1 + FW'(k) * S);
            wait_pulse(n);
            check(FW'(n), (k < 3) ? FW'(N) : 48'd60);
        end
        check(freq, T2);
        host.read_byte(ADDR_STATUS, rd);
        check(FW'(rd), FW'(8'h1a));
        host.set_pin(1'b0);
        wait_pulse(n);
        host.write_byte(ADDR_RATE + 2, 8'h05);
        wait_pulse(n);
        wait_pulse(n);
        check(FW'(n), 48'd6);
        settle(1);
        check(freq, T1);
        // mid-run reset must return to single tone at zero frequency
        @(posedge clk);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        settle(1);
        check(freq, '0);
        check(FW'(cos_w), '0);
        host.read_byte(ADDR_MODE_CTRL, rd);
        check(FW'(rd), '0);
        end_sim();
    end
endmodule
